// ===== hw/psu_unit.sv
// packed simd issue queue, packed move/pack datapath and fp timing
`timescale 1ns/1ps
`include "psu_map.svh"
module psu_unit #(
  parameter int QDEPTH = `PSU_QDEPTH,
  parameter int GPR_LAT = `PSU_DWMOV_GPR_LAT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic iss_valid,
  input wire logic [15:0] iss_opcode,
  input wire logic [7:0] iss_modrm,
  input wire psu_pkg::psu_range_t iss_range,
  input wire logic [31:0] iss_gpr_data,
  input wire logic [63:0] iss_mem_data,
  output logic iss_ready_ff,
  output logic gpr_wr_valid_ff,
  output logic [2:0] gpr_wr_idx_ff,
  output logic [31:0] gpr_wr_data_ff,
  output logic mem_wr_valid_ff,
  output logic mem_wr_qword_ff,
  output logic [63:0] mem_wr_data_ff,
  output logic [15:0] tag_word_ff,
  output logic [2:0] stack_top_ff,
  output logic fp_busy_ff,
  output logic done_ff
);
  import psu_pkg::*;

  localparam int PW = $clog2(QDEPTH);

  function automatic psu_op_t decode(logic [15:0] opc);
    psu_op_t op;
    op = OP_NOP;
    case (opc)
      `PSU_OPC_EMPTY: op = OP_EMPTY;
      `PSU_OPC_DWMOV_LD: op = OP_DWMOV_LD;
      `PSU_OPC_DWMOV_ST: op = OP_DWMOV_ST;
      `PSU_OPC_QWMOV_LD: op = OP_QWMOV_LD;
      `PSU_OPC_QWMOV_ST: op = OP_QWMOV_ST;
      `PSU_OPC_PACK_DW: op = OP_PACK_DW;
      `PSU_OPC_PACK_SWB: op = OP_PACK_SWB;
      `PSU_OPC_PACK_UWB: op = OP_PACK_UWB;
      `PSU_OPC_COS: op = OP_COS;
      `PSU_OPC_SIN: op = OP_SIN;
      `PSU_OPC_SINCOS: op = OP_SINCOS;
      `PSU_OPC_PTAN: op = OP_PTAN;
      `PSU_OPC_EXP2M1: op = OP_EXP2M1;
      `PSU_OPC_PATAN: op = OP_PATAN;
      `PSU_OPC_YL2XP1: op = OP_YL2XP1;
      `PSU_OPC_YL2X: op = OP_YL2X;
      // reserved codes retire as no-ops and raise nothing
      16'hd9d7, 16'hd9e2, 16'hd9e7, 16'hddfc, 16'hded8,
      16'hdeda, 16'hdedc, 16'hdedd, 16'hdede, 16'hdffc:
        op = OP_RSVD;
      default: op = OP_NOP;
    endcase
    return op;
  endfunction

  // cycles that a long floating op keeps the unit busy
  function automatic logic [7:0] fp_cycles(psu_op_t op, psu_range_t r);
    logic [7:0] c;
    logic trig;
    c = 8'(`PSU_CYC_FP_DEF);
    trig = 1'b0;
    case (op)
      OP_COS: begin
        trig = 1'b1;
        c = (r == RNG_SMALL) ? 8'(`PSU_CYC_COS_SMALL) : 8'(`PSU_CYC_COS_MID);
      end
      OP_SIN: begin
        trig = 1'b1;
        if (r == RNG_SMALL) c = 8'(`PSU_CYC_SIN_SMALL);
      end
      OP_SINCOS, OP_PTAN: trig = 1'b1;
      OP_EXP2M1: if (r == RNG_SMALL) c = 8'(`PSU_CYC_EXP2_SMALL);
      OP_PATAN: if (r == RNG_SMALL) c = 8'(`PSU_CYC_PATAN_SMALL);
      OP_YL2XP1: begin
        // out of range operand takes the longer PSU_CYC_YL2XP1_OOR count instead
        c = (r == RNG_REDUCE) ? 8'(`PSU_CYC_YL2XP1_OOR) : 8'(`PSU_CYC_YL2XP1);
      end
      OP_YL2X: c = 8'(`PSU_CYC_YL2X);
      default: c = 8'h01;
    endcase
    if (trig && r == RNG_REDUCE) c = c + 8'(`PSU_CYC_REDUCE);
    return c;
  endfunction

  function automatic logic [15:0] sat_s16(logic [31:0] v);
    logic [15:0] s;
    s = v[15:0];
    if (v[31] && !(&v[30:15])) s = 16'h8000;
    else if (!v[31] && (|v[30:15])) s = 16'h7fff;
    return s;
  endfunction

  function automatic logic [7:0] sat_b(logic [15:0] v, logic uns);
    logic [7:0] s;
    s = v[7:0];
    if (uns) begin
      if (v[15]) s = 8'h00;
      else if (|v[14:8]) s = 8'hff;
    end else begin
      if (v[15] && !(&v[14:7])) s = 8'h80;
      else if (!v[15] && (|v[14:7])) s = 8'h7f;
    end
    return s;
  endfunction

  // destination lanes fill the low half, source lanes the high half
  function automatic logic [63:0] pack_dw(logic [63:0] d, logic [63:0] s);
    return {sat_s16(s[63:32]), sat_s16(s[31:0]),
            sat_s16(d[63:32]), sat_s16(d[31:0])};
  endfunction

  function automatic logic [63:0] pack_wb(logic [63:0] d, logic [63:0] s,
                                          logic uns);
    logic [63:0] r;
    logic [127:0] w;
    r = 64'h0;
    w = {s, d};
    for (int i = 0; i < 8; i++) begin
      r[i*8 +: 8] = sat_b(w[i*16 +: 16], uns);
    end
    return r;
  endfunction

  // issue queue
  logic [15:0] q_opc [QDEPTH];
  logic [7:0] q_mod [QDEPTH];
  psu_range_t q_rng [QDEPTH];
  logic [31:0] q_gpr [QDEPTH];
  logic [63:0] q_mem [QDEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] cnt_ff;
  logic [63:0] regs [`PSU_NREGS];
  logic [7:0] fp_cnt_ff;
  logic [1:0] fp_stk_ff;
  logic gp_v [GPR_LAT-1];
  logic [2:0] gp_i [GPR_LAT-1];
  logic [31:0] gp_d [GPR_LAT-1];

  wire accept = iss_valid && iss_ready_ff;
  // the head waits while a long floating op is still running
  wire exec = (cnt_ff != '0) && !fp_busy_ff;
  wire [15:0] h_opc = q_opc[rd_ptr_ff];
  wire [7:0] h_mod = q_mod[rd_ptr_ff];
  wire psu_range_t h_rng = q_rng[rd_ptr_ff];
  wire [31:0] h_gpr = q_gpr[rd_ptr_ff];
  wire [63:0] h_mem = q_mem[rd_ptr_ff];
  wire psu_op_t h_op = decode(h_opc);
  wire h_regf = (h_mod[7:6] == 2'b11);
  wire [2:0] f1 = h_mod[5:3];
  wire [2:0] f2 = h_mod[2:0];
  wire [63:0] r1 = regs[f1];
  wire [63:0] r2 = regs[f2];
  wire [63:0] src = h_regf ? r2 : h_mem;
  wire h_long = (h_op >= OP_COS);
  wire [7:0] h_cyc = fp_cycles(h_op, h_rng);
  wire h_push = (h_op == OP_SINCOS) || (h_op == OP_PTAN);
  wire h_pop = (h_op == OP_PATAN) || (h_op == OP_YL2XP1) || (h_op == OP_YL2X);
  wire fp_last = fp_busy_ff && (fp_cnt_ff == 8'h01);

  wire [PW:0] nxt_cnt = cnt_ff + (PW+1)'(accept) - (PW+1)'(exec);
  wire [PW-1:0] nxt_wr = (wr_ptr_ff == PW'(QDEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [PW-1:0] nxt_rd = (rd_ptr_ff == PW'(QDEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;

  // register file write selection
  logic rf_we;
  logic [2:0] rf_idx;
  logic [63:0] rf_data;
  always_comb begin
    rf_we = 1'b0;
    rf_idx = f1;
    rf_data = src;
    case (h_op)
      OP_DWMOV_LD: begin
        rf_we = 1'b1;
        rf_data = {32'h0, h_regf ? h_gpr : h_mem[31:0]};
      end
      OP_QWMOV_LD: rf_we = 1'b1;
      OP_QWMOV_ST: begin
        rf_we = h_regf;
        rf_idx = f2;
        rf_data = r1;
      end
      OP_PACK_DW: begin
        rf_we = 1'b1;
        rf_data = pack_dw(r1, src);
      end
      OP_PACK_SWB, OP_PACK_UWB: begin
        rf_we = 1'b1;
        rf_data = pack_wb(r1, src, h_op == OP_PACK_UWB);
      end
      default: rf_we = 1'b0;
    endcase
  end

  wire st_d = exec && (h_op == OP_DWMOV_ST) && !h_regf;
  wire st_q = exec && (h_op == OP_QWMOV_ST) && !h_regf;
  wire gp_in = exec && (h_op == OP_DWMOV_ST) && h_regf;
  wire [2:0] nxt_top = fp_stk_ff[1] ? stack_top_ff + 3'h1 :
                       fp_stk_ff[0] ? stack_top_ff - 3'h1 : stack_top_ff;

  always_ff @(posedge core_clk) begin
    if (accept) begin
      q_opc[wr_ptr_ff] <= iss_opcode;
      q_mod[wr_ptr_ff] <= iss_modrm;
      q_rng[wr_ptr_ff] <= iss_range;
      q_gpr[wr_ptr_ff] <= iss_gpr_data;
      q_mem[wr_ptr_ff] <= iss_mem_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (exec && rf_we) regs[rf_idx] <= rf_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      iss_ready_ff <= 1'b1;
    end else begin
      if (accept) wr_ptr_ff <= nxt_wr;
      if (exec) rd_ptr_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      // ready is registered, so it must drop on the edge the queue fills
      iss_ready_ff <= (nxt_cnt < (PW+1)'(QDEPTH));
    end
  end

  // long floating ops: busy for exactly the counted cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fp_busy_ff <= 1'b0;
      fp_cnt_ff <= 8'h00;
      fp_stk_ff <= 2'b00;
      stack_top_ff <= `PSU_TOP_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (exec && !h_long) || fp_last;
      if (exec && h_long) begin
        fp_busy_ff <= 1'b1;
        fp_cnt_ff <= h_cyc;
        fp_stk_ff <= {h_pop, h_push};
      end else if (fp_busy_ff) begin
        fp_cnt_ff <= fp_cnt_ff - 8'h01;
        if (fp_last) begin
          fp_busy_ff <= 1'b0;
          // operands were read against the old top; move it only at the end
          stack_top_ff <= nxt_top;
          fp_stk_ff <= 2'b00;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tag_word_ff <= `PSU_TAG_RST;
      mem_wr_valid_ff <= 1'b0;
      mem_wr_qword_ff <= 1'b0;
      mem_wr_data_ff <= 64'h0;
    end else begin
      if (exec && h_op == OP_EMPTY) tag_word_ff <= `PSU_TAG_EMPTY;
      mem_wr_valid_ff <= st_d || st_q;
      mem_wr_qword_ff <= st_q;
      if (st_d) mem_wr_data_ff <= {32'h0, r1[31:0]};
      else if (st_q) mem_wr_data_ff <= r1;
    end
  end

  // gpr read-back pipe: a new one may enter every cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < GPR_LAT-1; i++) begin
        gp_v[i] <= 1'b0;
        gp_i[i] <= 3'h0;
        gp_d[i] <= 32'h0;
      end
      gpr_wr_valid_ff <= 1'b0;
      gpr_wr_idx_ff <= 3'h0;
      gpr_wr_data_ff <= 32'h0;
    end else begin
      gp_v[0] <= gp_in;
      gp_i[0] <= f2;
      gp_d[0] <= r1[31:0];
      for (int i = 1; i < GPR_LAT-1; i++) begin
        gp_v[i] <= gp_v[i-1];
        gp_i[i] <= gp_i[i-1];
        gp_d[i] <= gp_d[i-1];
      end
      gpr_wr_valid_ff <= gp_v[GPR_LAT-2];
      gpr_wr_idx_ff <= gp_i[GPR_LAT-2];
      gpr_wr_data_ff <= gp_d[GPR_LAT-2];
    end
  end
endmodule

// ===== hw/psu_map.svh
// constants for the packed simd issue and move unit
`ifndef PSU_MAP_SVH
`define PSU_MAP_SVH
`define PSU_QDEPTH 4
`define PSU_NREGS 8
`define PSU_OPC_EMPTY 16'h0f77
`define PSU_OPC_DWMOV_LD 16'h0f6e
`define PSU_OPC_DWMOV_ST 16'h0f7e
`define PSU_OPC_QWMOV_LD 16'h0f6f
`define PSU_OPC_QWMOV_ST 16'h0f7f
`define PSU_OPC_PACK_DW 16'h0f6b
`define PSU_OPC_PACK_SWB 16'h0f63
`define PSU_OPC_PACK_UWB 16'h0f67
`define PSU_OPC_COS 16'hd9ff
`define PSU_OPC_SIN 16'hd9fe
`define PSU_OPC_SINCOS 16'hd9fb
`define PSU_OPC_PTAN 16'hd9f2
`define PSU_OPC_EXP2M1 16'hd9f0
`define PSU_OPC_PATAN 16'hd9f3
`define PSU_OPC_YL2XP1 16'hd9f9
`define PSU_OPC_YL2X 16'hd9f1
`define PSU_CYC_REDUCE 90
`define PSU_CYC_COS_SMALL 141
`define PSU_CYC_COS_MID 92
`define PSU_CYC_SIN_SMALL 81
`define PSU_CYC_EXP2_SMALL 92
`define PSU_CYC_PATAN_SMALL 97
`define PSU_CYC_YL2XP1_OOR 170
`define PSU_CYC_YL2XP1 131
`define PSU_CYC_YL2X 145
`define PSU_CYC_FP_DEF 100
`define PSU_DWMOV_GPR_LAT 5
`define PSU_TAG_RST 16'hffff
`define PSU_TAG_EMPTY 16'hffff
`define PSU_TOP_RST 3'h0
`endif

// ===== hw/psu_pkg.sv
// types for the packed simd issue and move unit
package psu_pkg;
  // operand range class, sampled by the issuer with the instruction
  typedef enum logic [1:0] {
    RNG_SMALL, RNG_MID, RNG_WIDE, RNG_REDUCE
  } psu_range_t;
  typedef enum logic [4:0] {
    OP_NOP, OP_RSVD, OP_EMPTY, OP_DWMOV_LD, OP_DWMOV_ST, OP_QWMOV_LD,
    OP_QWMOV_ST, OP_PACK_DW, OP_PACK_SWB, OP_PACK_UWB, OP_COS, OP_SIN,
    OP_SINCOS, OP_PTAN, OP_EXP2M1, OP_PATAN, OP_YL2XP1, OP_YL2X
  } psu_op_t;
endpackage

// ===== sim/psu_monitor.sv
// concurrent checks on the packed simd unit ports
`timescale 1ns/1ps
module psu_monitor #(
  parameter int QDEPTH = 4,
  parameter int GPR_LAT = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic iss_valid,
  input wire logic iss_ready_ff,
  input wire logic gpr_wr_valid_ff,
  input wire logic mem_wr_valid_ff,
  input wire logic mem_wr_qword_ff,
  input wire logic [63:0] mem_wr_data_ff,
  input wire logic [15:0] tag_word_ff,
  input wire logic [2:0] stack_top_ff,
  input wire logic fp_busy_ff,
  input wire logic done_ff
);
  logic [8:0] blen_ff;
  logic [3:0] out_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // out_ff counts taken but not yet retired, an upper bound on queue use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blen_ff <= 9'h0;
      out_ff <= 4'h0;
    end else begin
      blen_ff <= fp_busy_ff ? blen_ff + 9'h1 : 9'h0;
      out_ff <= out_ff + 4'(iss_valid && iss_ready_ff) - 4'(done_ff);
    end
  end
  reset_state_a: assert property ($fell(rst) |-> iss_ready_ff && stack_top_ff == 3'h0 && !done_ff)
    else $error("outputs wrong after reset");
  tag_empty_a: assert property (tag_word_ff == 16'hffff)
    else $error("tag word not all empty");
  busy_len_a: assert property ($fell(fp_busy_ff) |-> blen_ff inside
    {9'd81, 9'd82, 9'd92, 9'd97, 9'd100, 9'd131, 9'd141, 9'd145, 9'd170, 9'd182, 9'd190, 9'd231})
    else $error("long op busy span not a legal count");
  busy_done_a: assert property ($fell(fp_busy_ff) |-> done_ff)
    else $error("no retire when busy ends");
  gpr_lat_a: assert property (gpr_wr_valid_ff |-> $past(done_ff, GPR_LAT - 1))
    else $error("gpr write not at fixed latency");
  store_done_a: assert property (mem_wr_valid_ff |-> done_ff)
    else $error("store not single cycle");
  dword_zero_a: assert property (mem_wr_valid_ff && !mem_wr_qword_ff |->
    mem_wr_data_ff[63:32] == 32'h0) else $error("dword store upper half not zero");
  queue_room_a: assert property (out_ff < 4'(QDEPTH) |-> iss_ready_ff)
    else $error("refused with queue room left");
  stack_step_a: assert property ($changed(stack_top_ff) |-> done_ff &&
    (stack_top_ff - $past(stack_top_ff)) inside {3'h1, 3'h7}) else $error("bad stack step");
endmodule
bind psu_unit psu_monitor #(.QDEPTH(QDEPTH), .GPR_LAT(GPR_LAT)) psu_monitor_inst (
  .core_clk(core_clk), .rst(rst), .iss_valid(iss_valid), .iss_ready_ff(iss_ready_ff),
  .gpr_wr_valid_ff(gpr_wr_valid_ff), .mem_wr_valid_ff(mem_wr_valid_ff),
  .mem_wr_qword_ff(mem_wr_qword_ff), .mem_wr_data_ff(mem_wr_data_ff),
  .tag_word_ff(tag_word_ff), .stack_top_ff(stack_top_ff), .fp_busy_ff(fp_busy_ff),
  .done_ff(done_ff));

// ===== sim/psu_issuer.sv
// issuing side model: offers one instruction at a time and honours ready
`timescale 1ns/1ps
module psu_issuer (
  input wire logic core_clk,
  input wire logic iss_ready_ff,
  output logic iss_valid,
  output logic [15:0] iss_opcode,
  output logic [7:0] iss_modrm,
  output psu_pkg::psu_range_t iss_range,
  output logic [31:0] iss_gpr_data,
  output logic [63:0] iss_mem_data
);
  import psu_pkg::*;
  initial begin
    iss_valid = 1'b0;
    iss_opcode = 16'h0;
    iss_modrm = 8'h0;
    iss_range = RNG_WIDE;
    iss_gpr_data = 32'h0;
    iss_mem_data = 64'h0;
  end
  // called just after an edge; returns once taken so the caller runs on
  task automatic send(logic [15:0] o, logic [7:0] m, psu_range_t r, logic [63:0] d);
    iss_valid = 1'b1;
    iss_opcode = o;
    iss_modrm = m;
    iss_range = r;
    iss_gpr_data = d[31:0];
    iss_mem_data = d;
    do @(posedge core_clk); while (iss_ready_ff !== 1'b1);
    #1;
  endtask
  // released opcode, modrm and data lines show junk so a stale instruction cannot pass for a new one; range keeps its value
  task automatic rel();
    iss_valid = 1'b0;
    iss_opcode = ~iss_opcode;
    iss_modrm = ~iss_modrm;
    iss_gpr_data = ~iss_gpr_data;
    iss_mem_data = ~iss_mem_data;
  endtask
endmodule

// ===== sim/packed_simd_issue_and_move_unit_tb.sv
// self-checking bench for the packed simd issue and move unit
`timescale 1ns/1ps
module packed_simd_issue_and_move_unit_tb;
  import psu_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic iss_valid, iss_ready_ff, gpr_wr_valid_ff, mem_wr_valid_ff, mem_wr_qword_ff;
  logic fp_busy_ff, done_ff;
  logic [15:0] iss_opcode, tag_word_ff;
  logic [7:0] iss_modrm;
  psu_range_t iss_range;
  logic [31:0] iss_gpr_data, gpr_wr_data_ff;
  logic [63:0] iss_mem_data, mem_wr_data_ff;
  logic [2:0] gpr_wr_idx_ff, stack_top_ff;
  int n_fail = 0;
  int checked = 0;
  int n_done = 0;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  psu_unit psu_unit_inst (.core_clk(core_clk), .rst(rst), .iss_valid(iss_valid),
    .iss_opcode(iss_opcode), .iss_modrm(iss_modrm), .iss_range(iss_range),
    .iss_gpr_data(iss_gpr_data), .iss_mem_data(iss_mem_data), .iss_ready_ff(iss_ready_ff),
    .gpr_wr_valid_ff(gpr_wr_valid_ff), .gpr_wr_idx_ff(gpr_wr_idx_ff),
    .gpr_wr_data_ff(gpr_wr_data_ff), .mem_wr_valid_ff(mem_wr_valid_ff),
    .mem_wr_qword_ff(mem_wr_qword_ff), .mem_wr_data_ff(mem_wr_data_ff),
    .tag_word_ff(tag_word_ff), .stack_top_ff(stack_top_ff), .fp_busy_ff(fp_busy_ff),
    .done_ff(done_ff));
  psu_issuer psu_issuer_inst (.core_clk(core_clk), .iss_ready_ff(iss_ready_ff),
    .iss_valid(iss_valid), .iss_opcode(iss_opcode), .iss_modrm(iss_modrm),
    .iss_range(iss_range), .iss_gpr_data(iss_gpr_data), .iss_mem_data(iss_mem_data));
  always @(posedge core_clk) begin
    if (done_ff === 1'b1) n_done++;
  end
  task automatic check(string nm, logic [71:0] seen, logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(logic [15:0] o, logic [7:0] m, logic [63:0] d, psu_range_t r = RNG_WIDE);
    // valid stays high between back-to-back sends; callers release before waiting
    psu_issuer_inst.send(o, m, r, d);
  endtask
  // store from a packed register and judge what reaches memory
  task automatic st(logic [15:0] o, logic [7:0] m, logic [63:0] exp, logic q);
    op(o, m, 64'h0);
    psu_issuer_inst.rel();
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (mem_wr_valid_ff === 1'b1) break;
    end
    check("store", {mem_wr_valid_ff, mem_wr_qword_ff, mem_wr_data_ff},
      {1'b1, q, exp});
  endtask
  task automatic t_moves();
    int k;
    op(16'h0f6e, 8'hd8, 64'hffff_ffff_8000_0001);
    st(16'h0f7f, 8'h18, 64'h8000_0001, 1'b1);
    op(16'h0f7e, 8'hdd, 64'h0);
    psu_issuer_inst.rel();
    k = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      k++;
      if (gpr_wr_valid_ff === 1'b1) break;
    end
    // a one-cycle op shows one edge after its take, so five cycles means k of 5
    check("gpr lat", 72'(k), 72'd5);
    check("gpr", {gpr_wr_valid_ff, gpr_wr_idx_ff, gpr_wr_data_ff},
      {1'b1, 3'h5, 32'h8000_0001});
    op(16'h0f6e, 8'h20, 64'hdead_beef_1357_9bdf);
    st(16'h0f7f, 8'h20, 64'h1357_9bdf, 1'b1);
    op(16'h0f6f, 8'h08, 64'h0123_4567_89ab_cdef);
    op(16'h0f7f, 8'hce, 64'h0);
    op(16'h0f6f, 8'hfe, 64'h0);
    st(16'h0f7f, 8'h38, 64'h0123_4567_89ab_cdef, 1'b1);
    st(16'h0f7e, 8'h38, 64'h89ab_cdef, 1'b0);
  endtask
  task automatic t_pack();
    logic [15:0] o[3] = '{16'h0f6b, 16'h0f63, 16'h0f67};
    logic [63:0] a[3] = '{64'h0001_0000_ffff_7fff, 64'h0100_ff00_0080_007f,
      64'h0100_ff00_0080_007f};
    // source is packed register 1, still holding 0123_4567_89ab_cdef from t_moves
    logic [63:0] e[3] = '{64'h7fff_8000_7fff_8000, 64'h7f7f_8080_7f80_7f7f,
      64'hffff_0000_ff00_807f};
    for (int i = 0; i < 3; i++) begin
      op(16'h0f6f, 8'h10, a[i]);
      op(o[i], 8'hd1, 64'h0);
      st(16'h0f7f, 8'h10, e[i], 1'b1);
    end
  endtask
  // long ops: busy span and stack pointer movement; reserved codes retire at once
  task automatic t_fp();
    logic [15:0] o[19] = '{16'hd9ff, 16'hd9ff, 16'hd9fe, 16'hd9fb, 16'hd9f2, 16'hd9f0,
      16'hd9f3, 16'hd9f9, 16'hd9f1, 16'hd9d7, 16'hd9e2, 16'hd9e7, 16'hddfc, 16'hded8,
      16'hdeda, 16'hdedc, 16'hdedd, 16'hdede, 16'hdffc};
    psu_range_t r[9] = '{RNG_SMALL, RNG_MID, RNG_SMALL, RNG_REDUCE, RNG_REDUCE, RNG_SMALL,
      RNG_SMALL, RNG_REDUCE, RNG_WIDE};
    int n[9] = '{141, 92, 81, 190, 190, 92, 97, 170, 145};
    logic [2:0] dl[9] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h1, 3'h1, 3'h1};
    logic [2:0] top;
    int cnt;
    top = 3'h0;
    for (int i = 0; i < 19; i++) begin
      cnt = 0;
      op(o[i], 8'h0, 64'h0, i < 9 ? r[i] : RNG_WIDE);
      psu_issuer_inst.rel();
      repeat (400) begin
        @(posedge core_clk);
        #1;
        if (fp_busy_ff === 1'b1) cnt++;
        if (done_ff === 1'b1) break;
      end
      if (i < 9) top = top + dl[i];
      check("busy span", 72'(cnt), i < 9 ? 72'(n[i]) : 72'h0);
      check("stack top", 72'(stack_top_ff), 72'(top));
    end
  endtask
  task automatic t_queue();
    int n0;
    n0 = n_done;
    psu_issuer_inst.send(16'hd9ff, 8'h0, RNG_SMALL, 64'h0);
    repeat (4) psu_issuer_inst.send(16'h0f77, 8'h0, RNG_WIDE, 64'h0);
    check("full", 72'(iss_ready_ff), 72'h0);
    psu_issuer_inst.send(16'h0f77, 8'h0, RNG_WIDE, 64'h0);
    psu_issuer_inst.rel();
    repeat (300) begin
      @(posedge core_clk);
      #1;
      if (n_done - n0 == 6) break;
    end
    check("retired", 72'(n_done - n0), 72'd6);
    check("tag", 72'(tag_word_ff), 72'hffff);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1;
    check("reset", {tag_word_ff, stack_top_ff, iss_ready_ff, fp_busy_ff, done_ff},
      {16'hffff, 3'h0, 3'b100});
    t_moves();
    t_pack();
    t_fp();
    t_queue();
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
